// ==== shared/nvsram_host_pkg.sv ====
// Constants, timing figures and state type for the nonvolatile SRAM host controller
package nvsram_host_pkg;

  // ****************************************************************
  // Bus widths
  // ****************************************************************
  localparam int ADDR_W      = 19;              // Byte address lines, 524,288 locations
  localparam int DATA_W      = 8;               // Byte-wide data lines
  localparam int CNT_W       = 24;              // Wait counter width
  localparam int SYNC_STAGES = 2;               // Flip-flops on every pin input

  // ****************************************************************
  // Clock and timing figures
  // ****************************************************************
  localparam int CLK_FREQ_MHZ        = 125;     // Controller clock rate
  localparam int WRITE_PULSE_NS      = 75;      // Least write pulse width
  localparam int WRITE_RECOVERY_NS   = 20;      // Least write recovery, chip select edge
  localparam int ACCESS_NS           = 100;     // Longest read access delay
  localparam int FLOAT_NS            = 35;      // Longest output float after deselect
  localparam int PROTECT_RECOVERY_MS = 125;     // Longest write protect after supply valid

  // Least time in ns to whole clock cycles, rounded up, at least one
  function automatic int ns_to_cycles_ceil(input int ns);
    int c;
    c = (ns * CLK_FREQ_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cycles_ceil

  localparam int WRITE_PULSE_CYC    = ns_to_cycles_ceil(WRITE_PULSE_NS);
  localparam int WRITE_RECOVERY_CYC = ns_to_cycles_ceil(WRITE_RECOVERY_NS);
  localparam int ACCESS_CYC         = ns_to_cycles_ceil(ACCESS_NS);
  localparam int FLOAT_CYC          = ns_to_cycles_ceil(FLOAT_NS);
  localparam int PROTECT_RECOVERY_CYC = PROTECT_RECOVERY_MS * 1000 * CLK_FREQ_MHZ;

  // Last counter values of each timed phase
  localparam logic [CNT_W-1:0] WP_LAST    = CNT_W'(WRITE_PULSE_CYC - 1);
  localparam logic [CNT_W-1:0] WR_LAST    = CNT_W'(WRITE_RECOVERY_CYC - 1);
  localparam logic [CNT_W-1:0] RD_LAST    = CNT_W'(ACCESS_CYC + SYNC_STAGES);
  localparam logic [CNT_W-1:0] FLOAT_LAST = CNT_W'(FLOAT_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO   = 24'h000000;
  localparam logic [CNT_W-1:0] CNT_ONE    = 24'h000001;

  // ****************************************************************
  // Controller states
  // ****************************************************************
  typedef enum logic [3:0] {
    POWER_WAIT,
    PROTECT_WAIT,
    IDLE,
    WR_SETUP,
    WR_PULSE,
    WR_RECOVER,
    RD_ACCESS,
    RD_FLOAT
  } host_state_t;

endpackage : nvsram_host_pkg

// ==== logic/pin_sync.sv ====
// Two-stage synchroniser for pin inputs from outside the clock domain
`timescale 1ns/10ps
module pin_sync
  import nvsram_host_pkg::*;
#(
  parameter int WIDTH = 1                        // Bits carried
)(
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // Asynchronous input and synchronised output
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  // ****************************************************************
  // Stages
  // ****************************************************************
  logic [WIDTH-1:0] meta_reg;                    // First stage, read only by second
  logic [WIDTH-1:0] sync_reg;                    // Second stage

  // Shift the pin through both stages
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;

endmodule : pin_sync

// ==== logic/nvsram_host.sv ====
// Host controller driving a byte-wide nonvolatile SRAM through its pins
//
// Contract
// - WE high, CS and OE low reads.
// - Write when WE and CS low, address first.
// - Address held steady during whole write.
// - WE high for recovery before next cycle.
// - OE kept high during write cycles.
// - Accesses resume only after supply valid.
`timescale 1ns/10ps
module nvsram_host
  import nvsram_host_pkg::*;
#(
  parameter int RECOVER_CYCLES = PROTECT_RECOVERY_CYC  // Wait after supply valid
)(
  // Clock and reset
  input  wire logic              MCLK_I,
  input  wire logic              NRST_I,
  // Supply supervisor pin, high while supply above protect threshold
  input  wire logic              SUPPLY_OK_I,
  // User request side
  input  wire logic              REQ_VALID_I,
  input  wire logic              REQ_WRITE_I,
  input  wire logic [ADDR_W-1:0] REQ_ADDR_I,
  input  wire logic [DATA_W-1:0] REQ_WDATA_I,
  output logic                   REQ_READY_O,
  output logic                   RESP_VALID_O,
  output logic      [DATA_W-1:0] RESP_RDATA_O,
  output logic                   LINK_READY_O,
  // Memory pins
  output logic      [ADDR_W-1:0] ADDR_LINES_O,
  output logic                   CHIP_SELECT_N_O,
  output logic                   WRITE_STROBE_N_O,
  output logic                   OUTPUT_DRIVE_N_O,
  input  wire logic [DATA_W-1:0] DATA_LINES_I,
  output logic      [DATA_W-1:0] DATA_LINES_O,
  output logic                   DATA_LINES_OE_O
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  localparam logic [CNT_W-1:0] REC_LAST = CNT_W'(RECOVER_CYCLES - 1);  // End of protect wait

  host_state_t       state_reg, state_next;      // Sequencer state
  logic [CNT_W-1:0]  cnt_reg, cnt_next;          // Phase timer
  logic [ADDR_W-1:0] addr_reg, addr_next;        // Address on the pins
  logic [DATA_W-1:0] dout_reg, dout_next;        // Write data on the pins
  logic              doe_reg, doe_next;          // Data drive enable
  logic              cs_n_reg, cs_n_next;        // Chip select, active low
  logic              we_n_reg, we_n_next;        // Write strobe, active low
  logic              oe_n_reg, oe_n_next;        // Output drive, active low
  logic              ready_reg, ready_next;      // Request acceptance
  logic              rvalid_reg, rvalid_next;    // Read answer pulse
  logic [DATA_W-1:0] rdata_reg, rdata_next;      // Read answer data
  logic              link_reg, link_next;        // Memory usable
  logic              supply_ok;                  // Synchronised supply good
  logic [DATA_W-1:0] data_sync;                  // Synchronised data lines

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  pin_sync #(.WIDTH(1)) supply_sync_u (
    .clk_i   (MCLK_I),
    .rst_n_i (NRST_I),
    .async_i (SUPPLY_OK_I),
    .sync_o  (supply_ok)
  );

  pin_sync #(.WIDTH(DATA_W)) data_sync_u (
    .clk_i   (MCLK_I),
    .rst_n_i (NRST_I),
    .async_i (DATA_LINES_I),
    .sync_o  (data_sync)
  );

  // ****************************************************************
  // Pin drive decode
  // ****************************************************************
  // Chip selected in setup, write pulse and read access only
  function automatic logic selects(input host_state_t s);
    return (s == WR_SETUP) || (s == WR_PULSE) || (s == RD_ACCESS);
  endfunction : selects

  // ****************************************************************
  // Sequencer next state
  // ****************************************************************
  always_comb
  begin
    state_next  = state_reg;
    cnt_next    = cnt_reg + CNT_ONE;
    addr_next   = addr_reg;
    dout_next   = dout_reg;
    rdata_next  = rdata_reg;
    rvalid_next = 1'b0;
    unique case (state_reg)
      // Supply below threshold, bus idle
      POWER_WAIT:
      begin
        cnt_next = CNT_ZERO;
        if (supply_ok)
          state_next = PROTECT_WAIT;
      end
      // Device may still write protect after supply valid
      PROTECT_WAIT:
      begin
        if (cnt_reg == REC_LAST)
        begin
          state_next = IDLE;
          cnt_next   = CNT_ZERO;
        end
      end
      // Take one request
      IDLE:
      begin
        cnt_next = CNT_ZERO;
        if (REQ_VALID_I)
        begin
          addr_next  = REQ_ADDR_I;
          dout_next  = REQ_WDATA_I;
          state_next = REQ_WRITE_I ? WR_SETUP : RD_ACCESS;
        end
      end
      // Address and chip select settle before strobe falls
      WR_SETUP:
      begin
        cnt_next   = CNT_ZERO;
        state_next = WR_PULSE;
      end
      // Strobe low for the least pulse width
      WR_PULSE:
      begin
        if (cnt_reg == WP_LAST)
        begin
          state_next = WR_RECOVER;
          cnt_next   = CNT_ZERO;
        end
      end
      // Strobe high for the least recovery time
      WR_RECOVER:
      begin
        if (cnt_reg == WR_LAST)
          state_next = IDLE;
      end
      // Access delay plus synchroniser latency, then capture
      RD_ACCESS:
      begin
        if (cnt_reg == RD_LAST)
        begin
          rdata_next  = data_sync;
          rvalid_next = 1'b1;
          state_next  = RD_FLOAT;
          cnt_next    = CNT_ZERO;
        end
      end
      // Let the device release the bus before the next cycle
      RD_FLOAT:
      begin
        if (cnt_reg == FLOAT_LAST)
          state_next = IDLE;
      end
    endcase
    // Supply loss aborts any cycle and deselects
    if (!supply_ok)
    begin
      state_next  = POWER_WAIT;
      cnt_next    = CNT_ZERO;
      rvalid_next = 1'b0;
    end
  end

  // ****************************************************************
  // Pin and status next values
  // ****************************************************************
  always_comb
  begin
    cs_n_next  = !selects(state_next);
    we_n_next  = (state_next != WR_PULSE);
    oe_n_next  = (state_next != RD_ACCESS);
    // Drive data from setup to one cycle past the strobe rising
    doe_next   = (state_next == WR_SETUP) || (state_next == WR_PULSE) ||
                 ((state_next == WR_RECOVER) && (state_reg == WR_PULSE));
    ready_next = (state_next == IDLE);
    link_next  = (state_next != POWER_WAIT) && (state_next != PROTECT_WAIT);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge MCLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      state_reg  <= POWER_WAIT;
      cnt_reg    <= CNT_ZERO;
      addr_reg   <= '0;
      dout_reg   <= '0;
      doe_reg    <= 1'b0;
      cs_n_reg   <= 1'b1;
      we_n_reg   <= 1'b1;
      oe_n_reg   <= 1'b1;
      ready_reg  <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      link_reg   <= 1'b0;
    end
    else
    begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      addr_reg   <= addr_next;
      dout_reg   <= dout_next;
      doe_reg    <= doe_next;
      cs_n_reg   <= cs_n_next;
      we_n_reg   <= we_n_next;
      oe_n_reg   <= oe_n_next;
      ready_reg  <= ready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg  <= rdata_next;
      link_reg   <= link_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign ADDR_LINES_O     = addr_reg;
  assign CHIP_SELECT_N_O  = cs_n_reg;
  assign WRITE_STROBE_N_O = we_n_reg;
  assign OUTPUT_DRIVE_N_O = oe_n_reg;
  assign DATA_LINES_O     = dout_reg;
  assign DATA_LINES_OE_O  = doe_reg;
  assign REQ_READY_O      = ready_reg;
  assign RESP_VALID_O     = rvalid_reg;
  assign RESP_RDATA_O     = rdata_reg;
  assign LINK_READY_O     = link_reg;

endmodule : nvsram_host

// ==== verification/nvsram_host_checker.sv ====
// Concurrent checks on the host controller's memory pins and read answers
`timescale 1ns/10ps
module nvsram_host_checker
  import nvsram_host_pkg::*;
#(
  parameter int RECOVER_CYCLES = 20                // Same as the controller's
)(
  input wire logic              MCLK_I,
  input wire logic              NRST_I,
  input wire logic              SUPPLY_OK_I,
  input wire logic              RESP_VALID_O,
  input wire logic [ADDR_W-1:0] ADDR_LINES_O,
  input wire logic              CHIP_SELECT_N_O,
  input wire logic              WRITE_STROBE_N_O,
  input wire logic              OUTPUT_DRIVE_N_O,
  input wire logic [DATA_W-1:0] DATA_LINES_O,
  input wire logic              DATA_LINES_OE_O
);
  // ****************************************************************
  // Pin timing and ordering
  // ****************************************************************
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!NRST_I);
  a_strobe_needs_select: assert property (!WRITE_STROBE_N_O |-> !CHIP_SELECT_N_O)
    else $error("Write strobe low without chip select");
  a_select_before_strobe: assert property ($fell(WRITE_STROBE_N_O) |-> !$past(CHIP_SELECT_N_O))
    else $error("Write strobe fell without chip select set up");
  a_pulse_width: assert property ($fell(WRITE_STROBE_N_O) |-> ##9 !WRITE_STROBE_N_O ##1 WRITE_STROBE_N_O)
    else $error("Write pulse not ten cycles");
  a_data_hold: assert property ($rose(WRITE_STROBE_N_O) |-> DATA_LINES_OE_O && $stable(DATA_LINES_O))
    else $error("Write data not held at strobe end");
  a_addr_steady: assert property (!CHIP_SELECT_N_O && !$past(CHIP_SELECT_N_O) |-> $stable(ADDR_LINES_O))
    else $error("Address moved inside a cycle");
  a_write_recovery: assert property ($rose(WRITE_STROBE_N_O) |-> CHIP_SELECT_N_O [*3])
    else $error("Next cycle started inside recovery");
  a_drive_off_write: assert property (!WRITE_STROBE_N_O || DATA_LINES_OE_O |-> OUTPUT_DRIVE_N_O)
    else $error("Output drive low during a write");
  a_read_length: assert property ($fell(OUTPUT_DRIVE_N_O) |-> ##15 !OUTPUT_DRIVE_N_O ##1 (OUTPUT_DRIVE_N_O && RESP_VALID_O))
    else $error("Read window or answer mistimed");
  a_answer_pulse: assert property (RESP_VALID_O |=> !RESP_VALID_O)
    else $error("Read answer longer than one cycle");
  a_supply_quiet: assert property (!SUPPLY_OK_I [*4] |-> CHIP_SELECT_N_O && WRITE_STROBE_N_O && OUTPUT_DRIVE_N_O)
    else $error("Memory pins active without supply");
endmodule : nvsram_host_checker

bind nvsram_host nvsram_host_checker #(.RECOVER_CYCLES(RECOVER_CYCLES)) nvsram_host_checker_i (
  .MCLK_I(MCLK_I), .NRST_I(NRST_I), .SUPPLY_OK_I(SUPPLY_OK_I), .RESP_VALID_O(RESP_VALID_O),
  .ADDR_LINES_O(ADDR_LINES_O), .CHIP_SELECT_N_O(CHIP_SELECT_N_O),
  .WRITE_STROBE_N_O(WRITE_STROBE_N_O), .OUTPUT_DRIVE_N_O(OUTPUT_DRIVE_N_O),
  .DATA_LINES_O(DATA_LINES_O), .DATA_LINES_OE_O(DATA_LINES_OE_O));

// ==== verification/nvsram_model.sv ====
// Behavioural byte-wide nonvolatile SRAM on the far side of the host pins
`timescale 1ns/10ps
module nvsram_model
  import nvsram_host_pkg::*;
(
  input  wire logic              clk_i,         // Steps the float pattern
  input  wire logic              supply_ok_i,   // High while supply is valid
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic              cs_n_i,
  input  wire logic              we_n_i,
  input  wire logic              oe_n_i,
  input  wire logic [DATA_W-1:0] dq_i,          // Resolved data wire
  output logic      [DATA_W-1:0] dq_o           // Read byte or float pattern
);
  // ****************************************************************
  // Storage, drive and capture
  // ****************************************************************
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];  // Sparse byte array
  logic [DATA_W-1:0] pat = 8'h00;               // Floating bus, new value each cycle
  logic              armed = 1'b0;              // Backup source connected
  logic              drive;
  logic              valid_late = 1'b0;         // Access delay has run out since enable
  localparam int     PROTECT_NS = 150;          // Write protect after supply returns
  time               prot_end = 0;              // Writes ignored before this time
  wire write_on = supply_ok_i && !cs_n_i && !we_n_i;
  assign drive = supply_ok_i && !cs_n_i && !oe_n_i && we_n_i;
  // Validity drops at once on release, but a rise still pending from an earlier select is not cancelled
  always @(drive)
  begin
    valid_late <= 1'b0;
    if (drive) valid_late <= #(ACCESS_NS) 1'b1;
  end
  always @(posedge clk_i) pat <= pat + 8'h3B;
  // Byte latched at the earlier rising edge
  always @(negedge write_on) if (supply_ok_i && ($time >= prot_end)) mem[addr_i] = dq_i;
  // Seal opens on first supply, writes stay blocked for a while after each return
  always @(posedge supply_ok_i)
  begin
    armed = 1'b1;
    prot_end = $time + PROTECT_NS;
  end
  always @(negedge supply_ok_i) if (!armed) mem.delete();
  always @* dq_o = (drive && valid_late) ? (mem.exists(addr_i) ? mem[addr_i] : ~addr_i[7:0]) : pat;
endmodule : nvsram_model

// ==== verification/nvsram_host_tb.sv ====
// Self-checking bench for the nonvolatile SRAM host controller
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin error_cnt++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module nvsram_host_tb
  import nvsram_host_pkg::*;
;
  logic              mclk, nrst, supply_ok, req_valid, req_write;
  logic              req_ready, resp_valid, link_ready, cs_n, we_n, oe_n, dq_oe;
  logic [ADDR_W-1:0] req_addr, addr;
  logic [DATA_W-1:0] req_wdata, resp_rdata, dq_host, dev_q, dq_wire;
  logic [DATA_W-1:0] ref_mem [logic [ADDR_W-1:0]]; // Expected contents
  logic [ADDR_W-1:0] used [$];                     // Addresses written by the random loop
  logic [31:0]       seed = 32'h00003049;
  logic [31:0]       r;
  int                error_cnt = 0;
  int                comparisons = 0;
  // ****************************************************************
  // Parts, wire and helpers
  // ****************************************************************
  assign dq_wire = dq_oe ? dq_host : dev_q;
  nvsram_host #(.RECOVER_CYCLES(20)) nvsram_host_i (.MCLK_I(mclk), .NRST_I(nrst),
    .SUPPLY_OK_I(supply_ok), .REQ_VALID_I(req_valid), .REQ_WRITE_I(req_write),
    .REQ_ADDR_I(req_addr), .REQ_WDATA_I(req_wdata), .REQ_READY_O(req_ready),
    .RESP_VALID_O(resp_valid), .RESP_RDATA_O(resp_rdata), .LINK_READY_O(link_ready),
    .ADDR_LINES_O(addr), .CHIP_SELECT_N_O(cs_n), .WRITE_STROBE_N_O(we_n),
    .OUTPUT_DRIVE_N_O(oe_n), .DATA_LINES_I(dq_wire), .DATA_LINES_O(dq_host),
    .DATA_LINES_OE_O(dq_oe));
  nvsram_model nvsram_model_i (.clk_i(mclk), .supply_ok_i(supply_ok), .addr_i(addr),
    .cs_n_i(cs_n), .we_n_i(we_n), .oe_n_i(oe_n), .dq_i(dq_wire), .dq_o(dev_q));
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic summarize();
    $display("Counts: %0d compared, %0d failed", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  // Bounded wait on ready (0), link (1) or answer (2)
  task automatic wait_sig(input int sel, input int lim);
    int   n;
    logic s;
    n = 0;
    s = 1'b0;
    while (s !== 1'b1)
    begin
      @(negedge mclk);
      s = (sel == 0) ? req_ready : (sel == 1) ? link_ready : resp_valid;
      n++;
      if (n > lim)
      begin
        error_cnt++;
        $display("CHECK FAILED wait %0d exp 1 got 0", sel);
        summarize();
      end
    end
  endtask : wait_sig
  // One request; a read is compared against the expected byte
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    wait_sig(0, 40);
    @(posedge mclk);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    @(posedge mclk);
    req_valid <= 1'b0;
    if (w) ref_mem[a] = d;
    else
    begin
      wait_sig(2, 40);
      `CHK("rdata", ref_mem[a], resp_rdata)
    end
  endtask : xfer
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    nrst = 1'b0;
    supply_ok = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 19'h00000;
    req_wdata = 8'h00;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    supply_ok <= 1'b1;
    wait_sig(1, 100);
    // End addresses, back-to-back overwrite
    xfer(1'b1, 19'h00000, 8'h5A);
    xfer(1'b1, 19'h7FFFF, 8'hC3);
    xfer(1'b1, 19'h7FFFF, 8'h3C);
    xfer(1'b0, 19'h00000, 8'h00);
    xfer(1'b0, 19'h7FFFF, 8'h00);
    $display("TEST corners done");
    for (int i = 0; i < 40; i++)
    begin
      r = xs();
      if (r[31] && used.size() > 0) xfer(1'b0, used[r[30:20] % used.size()], 8'h00);
      else
      begin
        xfer(1'b1, r[18:0], r[26:19]);
        used.push_back(r[18:0]);
      end
    end
    $display("TEST random done");
    // Let the last cycle finish so the supply drop meets an idle bus
    wait_sig(0, 40);
    // Supply loss: pins quiet, request ignored, contents kept
    @(posedge mclk);
    supply_ok <= 1'b0;
    repeat (6) @(negedge mclk);
    `CHK("link", 1'b0, link_ready)
    `CHK("ready", 1'b0, req_ready)
    @(posedge mclk);
    req_valid <= 1'b1;
    req_write <= 1'b1;
    req_addr <= 19'h00000;
    req_wdata <= 8'hFF;
    repeat (4) @(posedge mclk);
    req_valid <= 1'b0;
    supply_ok <= 1'b1;
    wait_sig(1, 100);
    xfer(1'b0, 19'h00000, 8'h00);
    xfer(1'b1, 19'h00000, 8'h81);
    xfer(1'b0, 19'h00000, 8'h00);
    $display("TEST supply done");
    summarize();
  end
endmodule : nvsram_host_tb
